// File: hdl/umf_top.sv
/*
   Modem control, diagnostic loopback and automatic flow control of a
   serial port. Holds the modem line control and modem status registers,
   the automatic request-to-send hysteresis, the clear-to-send start gate
   and the registered modem and serial pin drivers.
   Assumes the receive FIFO level and trigger code come from the port's
   FIFO logic on the same clock, and that the transmit shift register
   asks before each character, holds its request until granted, and
   reports when it is busy. Modem inputs and the receive pin are
   asynchronous and are synchronised here; every other input is on clk_i.
   Register reads answer one cycle after the strobe and never wait.
*/
`default_nettype none
`include "umf_defines.svh"
module umf_top #(
   parameter int LEVEL_W = 5
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [31:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Receive FIFO side
   input wire logic [LEVEL_W-1:0] rx_level_i,
   input wire logic [1:0] rx_trigger_i,
   output logic rx_serial_o,
   // Transmit shift register side
   input wire logic tx_serial_i,
   input wire logic tx_start_req_i,
   input wire logic tx_busy_i,
   output logic tx_start_o,
   output logic tx_stalled_o,
   // Modem status event towards the port's interrupt logic
   output logic modem_status_event_o,
   // Pins
   input wire logic serial_rx_pin_i,
   output logic serial_tx_pin_o,
   input wire logic clear_to_send_in_n_i,
   input wire logic dsr_n_i,
   input wire logic ri_n_i,
   input wire logic dcd_n_i,
   output logic request_to_send_out_n_o,
   output logic dtr_n_o
);

   // Threshold for a trigger code
   function automatic logic [LEVEL_W-1:0] trig_level(input logic [1:0] code);
      logic [4:0] t;
      t = `UMF_TRIG_L0;
      case (code)
         2'h0: t = `UMF_TRIG_L0;
         2'h1: t = `UMF_TRIG_L1;
         2'h2: t = `UMF_TRIG_L2;
         2'h3: t = `UMF_TRIG_L3;
         default: t = `UMF_TRIG_L0;
      endcase
      return LEVEL_W'(t);
   endfunction : trig_level

   // Threshold one setting below a trigger code, empty below the lowest
   function automatic logic [LEVEL_W-1:0] prev_level(input logic [1:0] code);
      logic [LEVEL_W-1:0] p;
      p = LEVEL_W'(`UMF_TRIG_ZERO);
      if (code != 2'h0) begin
         p = trig_level(code - 2'h1);
      end
      return p;
   endfunction : prev_level

   // Register select for one mapped address
   function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] target);
      return addr == target;
   endfunction : reg_hit

   umf_sync_if sync_bus ();

   logic [7:0] mcr_r;
   logic [7:0] mcr_nxt;
   logic [3:0] msr_delta_r;
   logic [3:0] msr_delta_nxt;
   logic [3:0] lines_prev_r;
   logic [3:0] lines_now;
   logic [3:0] lines_chg;
   logic rts_hold_r;
   logic rts_auto;
   logic rts_assert;
   logic [LEVEL_W-1:0] hi_thr;
   logic [LEVEL_W-1:0] lo_thr;
   logic loop_on;
   logic auto_rts;
   logic auto_cts;
   logic cts_ok;
   logic rx_serial_nxt;
   logic wr_mcr;
   logic rd_mcr;
   logic rd_msr;
   logic [7:0] mcr_view;
   logic [7:0] msr_view;
   logic [7:0] rdata_nxt;
   umf_pkg::umf_tx_e tx_st_r;
   umf_pkg::umf_tx_e tx_st_nxt;

   // Synchronise modem inputs and receive pin
   umf_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .cts_n_i(clear_to_send_in_n_i),
      .dsr_n_i(dsr_n_i),
      .ri_n_i(ri_n_i),
      .dcd_n_i(dcd_n_i),
      .rxd_i(serial_rx_pin_i),
      .sync(sync_bus.src)
   );

   // Mode decodes
   assign loop_on = mcr_r[`UMF_MCR_LOOP];
   assign auto_rts = mcr_r[`UMF_MCR_ARTS];
   assign auto_cts = mcr_r[`UMF_MCR_ACTS];

   // Register strobes, one decode per mapped address
   assign wr_mcr = wr_i && reg_hit(addr_i, `UMF_MCR_ADDR);
   assign rd_mcr = rd_i && reg_hit(addr_i, `UMF_MCR_ADDR);
   assign rd_msr = rd_i && reg_hit(addr_i, `UMF_MSR_ADDR);

   // Deassert and reassert thresholds for the current trigger code
   assign hi_thr = trig_level(rx_trigger_i);
   assign lo_thr = prev_level(rx_trigger_i);

   // Automatic request-to-send hysteresis on the receive FIFO level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rts_hold_r <= 1'b0;
      end else if (!auto_rts) begin
         rts_hold_r <= 1'b0;
      end else if (rx_level_i >= hi_thr) begin
         rts_hold_r <= 1'b1;
      end else if (rx_level_i <= lo_thr) begin
         rts_hold_r <= 1'b0;
      end
   end

   // Request level that the hysteresis asks for in automatic mode
   assign rts_auto = ~rts_hold_r;

   // Request asserted: hardware in auto mode, the control bit otherwise
   assign rts_assert = auto_rts ? rts_auto : mcr_r[`UMF_MCR_RTS];

   // Control register update
   always_comb begin
      mcr_nxt = mcr_r;
      if (wr_mcr) begin
         mcr_nxt = wdata_i & `UMF_MCR_WMASK;
         if (auto_rts && wdata_i[`UMF_MCR_ARTS]) begin
            mcr_nxt[`UMF_MCR_RTS] = mcr_r[`UMF_MCR_RTS];
         end
      end
      if (auto_rts && (!wr_mcr || wdata_i[`UMF_MCR_ARTS])) begin
         mcr_nxt[`UMF_MCR_RTS] = rts_auto;
      end
   end

   // Modem line control register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mcr_r <= `UMF_MCR_RESET;
      end else begin
         mcr_r <= mcr_nxt;
      end
   end

   // Status lines: control nibble in loopback, pins otherwise
   always_comb begin
      if (loop_on) begin
         lines_now[0] = mcr_r[`UMF_MCR_RTS];
         lines_now[1] = mcr_r[`UMF_MCR_DTR];
         lines_now[2] = mcr_r[`UMF_MCR_OUT1];
         lines_now[3] = mcr_r[`UMF_MCR_OUT2];
      end else begin
         lines_now[0] = sync_bus.cts;
         lines_now[1] = sync_bus.dsr;
         lines_now[2] = sync_bus.ri;
         lines_now[3] = sync_bus.dcd;
      end
   end

   // Change detection, ring indicator on trailing edge only
   assign lines_chg[0] = lines_now[0] ^ lines_prev_r[0];
   assign lines_chg[1] = lines_now[1] ^ lines_prev_r[1];
   assign lines_chg[2] = lines_prev_r[2] & ~lines_now[2];
   assign lines_chg[3] = lines_now[3] ^ lines_prev_r[3];

   // Previous line levels
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lines_prev_r <= 4'h0;
      end else begin
         lines_prev_r <= lines_now;
      end
   end

   // Sticky deltas: read clears, a new change wins over the clear
   always_comb begin
      msr_delta_nxt = msr_delta_r;
      if (rd_msr) begin
         msr_delta_nxt = 4'h0;
      end
      msr_delta_nxt = msr_delta_nxt | lines_chg;
   end

   // Modem status delta bits
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         msr_delta_r <= 4'h0;
      end else begin
         msr_delta_r <= msr_delta_nxt;
      end
   end

   // Any pending delta is reported to the interrupt logic
   assign modem_status_event_o = |msr_delta_r;

   // Control register as software reads it
   always_comb begin
      mcr_view = mcr_r;
      mcr_view[`UMF_MCR_RSVD] = 1'b0;
      if (loop_on) begin
         mcr_view[`UMF_MCR_DTR] = 1'b0;
         mcr_view[`UMF_MCR_RTS] = 1'b0;
      end
   end

   // Status register: line levels above sticky deltas
   assign msr_view = {lines_now, msr_delta_r};

   // Read data, one cycle after the strobe, zero when unmapped or idle
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_mcr) begin
         rdata_nxt = mcr_view;
      end else if (rd_msr) begin
         rdata_nxt = msr_view;
      end
   end

   // Read data register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rdata_nxt;
      end
   end

   // Clear-to-send gate for the transmitter
   assign cts_ok = !auto_cts || lines_now[0];

   // Transmit start gate state
   always_comb begin
      tx_st_nxt = tx_st_r;
      case (tx_st_r)
         umf_pkg::UMF_TX_IDLE: begin
            if (tx_start_req_i && cts_ok) begin
               tx_st_nxt = umf_pkg::UMF_TX_BUSY;
            end else if (tx_start_req_i) begin
               tx_st_nxt = umf_pkg::UMF_TX_STALL;
            end
         end
         umf_pkg::UMF_TX_STALL: begin
            if (!tx_start_req_i) begin
               tx_st_nxt = umf_pkg::UMF_TX_IDLE;
            end else if (cts_ok) begin
               tx_st_nxt = umf_pkg::UMF_TX_BUSY;
            end
         end
         umf_pkg::UMF_TX_BUSY: begin
            if (!tx_busy_i && !tx_start_req_i) begin
               tx_st_nxt = umf_pkg::UMF_TX_IDLE;
            end
         end
         default: tx_st_nxt = umf_pkg::UMF_TX_IDLE;
      endcase
   end

   // Gate state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_st_r <= umf_pkg::UMF_TX_IDLE;
      end else begin
         tx_st_r <= tx_st_nxt;
      end
   end

   // Start is granted only with a request and, in auto clear-to-send mode, a clear line
   assign tx_start_o = tx_start_req_i && cts_ok && (tx_st_r != umf_pkg::UMF_TX_BUSY);
   assign tx_stalled_o = (tx_st_r == umf_pkg::UMF_TX_STALL);

   // Receiver serial input: own transmitter in loopback, pin otherwise
   assign rx_serial_nxt = loop_on ? tx_serial_i : sync_bus.rxd;

   // Receiver serial input register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_serial_o <= `UMF_LINE_IDLE;
      end else begin
         rx_serial_o <= rx_serial_nxt;
      end
   end

   // Transmit pin; a stalled shifter idles high, so the line marks until clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_tx_pin_o <= `UMF_LINE_IDLE;
      end else begin
         serial_tx_pin_o <= loop_on ? `UMF_LINE_IDLE : tx_serial_i;
      end
   end

   // Terminal-ready pin, active low, inactive in loopback
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dtr_n_o <= `UMF_PIN_INACTIVE;
      end else if (loop_on) begin
         dtr_n_o <= `UMF_PIN_INACTIVE;
      end else begin
         dtr_n_o <= ~mcr_r[`UMF_MCR_DTR];
      end
   end

   // Request-to-send pin, active low, inactive in loopback
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         request_to_send_out_n_o <= `UMF_PIN_INACTIVE;
      end else if (loop_on) begin
         request_to_send_out_n_o <= `UMF_PIN_INACTIVE;
      end else begin
         request_to_send_out_n_o <= ~rts_assert;
      end
   end

endmodule : umf_top
`default_nettype wire

// File: hdl/umf_defines.svh
/*
   Constants for the modem-control and flow-control block of the serial port.
   Assumes it is included by bare name from every design file that needs it.
*/
`ifndef UMF_DEFINES_SVH
`define UMF_DEFINES_SVH

// Register byte addresses
`define UMF_MCR_ADDR 32'he001_0010
`define UMF_MSR_ADDR 32'he001_0018

// Modem line control fields
`define UMF_MCR_DTR 0
`define UMF_MCR_RTS 1
`define UMF_MCR_OUT1 2
`define UMF_MCR_OUT2 3
`define UMF_MCR_LOOP 4
`define UMF_MCR_ARTS 6
`define UMF_MCR_ACTS 7
`define UMF_MCR_RSVD 5
`define UMF_MCR_RESET 8'h00
`define UMF_MCR_WMASK 8'hdf

// Modem status fields
`define UMF_MSR_DCTS 0
`define UMF_MSR_DDSR 1
`define UMF_MSR_TERI 2
`define UMF_MSR_DDCD 3
`define UMF_MSR_CTS 4
`define UMF_MSR_DSR 5
`define UMF_MSR_RI 6
`define UMF_MSR_DCD 7

// Receive trigger thresholds in characters
`define UMF_TRIG_ZERO 5'h00
`define UMF_TRIG_L0 5'h01
`define UMF_TRIG_L1 5'h04
`define UMF_TRIG_L2 5'h08
`define UMF_TRIG_L3 5'h0e

// Idle and inactive pin levels
`define UMF_LINE_IDLE 1'b1
`define UMF_PIN_INACTIVE 1'b1

`endif

// File: hdl/umf_pkg.sv
/*
   Types shared by the modem-control block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package umf_pkg;
   // Transmit start gate states
   typedef enum logic [1:0] {
      UMF_TX_IDLE = 2'b00,
      UMF_TX_STALL = 2'b01,
      UMF_TX_BUSY = 2'b10
   } umf_tx_e;
endpackage : umf_pkg
`default_nettype wire

// File: hdl/umf_sync_if.sv
/*
   Carrier of synchronised modem and serial inputs, asserted-high sense
   for modem lines, raw level for receive data.
   Assumes one producer (the synchroniser) and one consumer.
*/
`default_nettype none
interface umf_sync_if;
   logic cts;
   logic dsr;
   logic ri;
   logic dcd;
   logic rxd;
   modport src (output cts, output dsr, output ri, output dcd, output rxd);
   modport dst (input cts, input dsr, input ri, input dcd, input rxd);
endinterface : umf_sync_if
`default_nettype wire

// File: hdl/umf_sync.sv
/*
   Two-stage synchroniser for the modem inputs and receive pin.
   Assumes active-low modem pins and an idle-high receive line.
*/
`default_nettype none
`include "umf_defines.svh"
module umf_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic ri_n_i,
   input wire logic dcd_n_i,
   input wire logic rxd_i,
   umf_sync_if.src sync
);
   logic [4:0] meta_r;
   logic [4:0] stab_r;

   // First stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= 5'h1f;
         stab_r <= 5'h1f;
      end else begin
         meta_r <= {rxd_i, dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
         stab_r <= meta_r;
      end
   end

   // Asserted-high view of the modem lines
   assign sync.cts = ~stab_r[0];
   assign sync.dsr = ~stab_r[1];
   assign sync.ri = ~stab_r[2];
   assign sync.dcd = ~stab_r[3];
   assign sync.rxd = stab_r[4];
endmodule : umf_sync
`default_nettype wire

// File: tb/umf_remote.sv
/*
   Remote serial port on the handshake lines: modem inputs and frames on the receive pin.
   Assumes the bench commands line levels and when a frame may begin.
*/
`default_nettype none
module umf_remote (
   input wire logic clk_i,
   input wire logic rts_n_i,
   input wire logic go_i,
   input wire logic [3:0] lines_i,
   output logic cts_n_o,
   output logic dsr_n_o,
   output logic ri_n_o,
   output logic dcd_n_o,
   output logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lin_r = 4'h0;
   logic [9:0] sh_r = 10'h3ff;
   logic [3:0] cnt_r = 4'h0;
   // Modem lines change just after an edge, active low
   always @(posedge clk_i) begin
      lin_r <= lines_i;
   end
   assign {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} = ~lin_r;
   // A frame once begun runs out even after request-to-send drops
   always @(posedge clk_i) begin
      if (cnt_r != 4'h0) begin
         sh_r <= {1'b1, sh_r[9:1]};
         cnt_r <= cnt_r - 4'h1;
      end else if (go_i && !rts_n_i) begin
         sh_r <= {1'b1, 8'ha5, 1'b0};
         cnt_r <= 4'ha;
      end
   end
   assign rxd_o = sh_r[0];
endmodule : umf_remote
`default_nettype wire

// File: tb/umf_top_sva.sv
/*
   Checker for register-to-pin timing, loopback and automatic flow control.
   Assumes it is bound to umf_top and sees only its ports.
*/
`default_nettype none
`include "umf_defines.svh"
module umf_top_sva #(
   parameter int LEVEL_W = 5
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [31:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [LEVEL_W-1:0] rx_level_i,
   input wire logic [1:0] rx_trigger_i,
   input wire logic tx_start_req_i,
   input wire logic tx_busy_i,
   input wire logic tx_start_o,
   input wire logic serial_tx_pin_o,
   input wire logic clear_to_send_in_n_i,
   input wire logic request_to_send_out_n_o,
   input wire logic dtr_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   localparam logic [4:0] THR [5] = '{5'h00, 5'h01, 5'h04, 5'h08, 5'h0e};
   logic [7:0] ctl_r;
   logic mcr_w;
   // Shadow of the control register from bus writes
   assign mcr_w = wr_i && addr_i == `UMF_MCR_ADDR;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctl_r <= 8'h00;
      end else if (mcr_w) begin
         ctl_r <= wdata_i;
      end
   end
   chk_dtr_follow: assert property (
      mcr_w && !wdata_i[4] |-> ##2 dtr_n_o == !$past(wdata_i[0], 2))
      else $error("dtr pin wrong after write");
   chk_rts_follow: assert property (
      mcr_w && !wdata_i[4] && !wdata_i[6] |-> ##2 request_to_send_out_n_o == !$past(wdata_i[1], 2))
      else $error("rts pin wrong after write");
   chk_loop_read: assert property (
      rd_i && addr_i == `UMF_MCR_ADDR && ctl_r[4] |=> rdata_o[1:0] == 2'b00)
      else $error("loopback read shows control bits");
   chk_loop_pins: assert property (
      mcr_w && wdata_i[4] |-> ##2 dtr_n_o && request_to_send_out_n_o && serial_tx_pin_o)
      else $error("pins active in loopback");
   chk_rts_high: assert property (
      ctl_r[6] && rx_level_i >= THR[{1'b0, rx_trigger_i} + 3'h1]
      |-> ##2 (request_to_send_out_n_o || !ctl_r[6]))
      else $error("rts not dropped at trigger");
   chk_rts_low: assert property (
      ctl_r[6] && !ctl_r[4] && rx_level_i <= THR[rx_trigger_i]
      |-> ##2 (!request_to_send_out_n_o || !ctl_r[6] || ctl_r[4]))
      else $error("rts not restored at lower level");
   chk_cts_gate: assert property (
      ctl_r[7] && !ctl_r[4] && $past(clear_to_send_in_n_i) && $past(clear_to_send_in_n_i, 2)
      |-> !tx_start_o)
      else $error("start granted without clear");
   chk_cts_off: assert property (
      !ctl_r[7] && !$past(tx_start_req_i) && !$past(tx_busy_i) |-> tx_start_o == tx_start_req_i)
      else $error("start gated with auto clear off");
   cover property (ctl_r[6] && request_to_send_out_n_o);
   cover property (ctl_r[7] && tx_start_req_i && !tx_start_o);
   cover property (rd_i && ctl_r[4]);
endmodule : umf_top_sva
bind umf_top umf_top_sva #(.LEVEL_W(LEVEL_W)) i_sva (.clk_i, .rst_n_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .rdata_o, .rx_level_i, .rx_trigger_i, .tx_start_req_i, .tx_busy_i,
   .tx_start_o, .serial_tx_pin_o, .clear_to_send_in_n_i, .request_to_send_out_n_o, .dtr_n_o);
`default_nettype wire

// File: tb/tb_umf_top.sv
/*
   Bench for the modem-control block: control table, loopback, auto flow control.
   Assumes umf_top, umf_remote and the checker are compiled first.
*/
`default_nettype none
`include "umf_defines.svh"
module tb_umf_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] d;
   logic wr = 1'b0, rd = 1'b0, go = 1'b0, req = 1'b0, busy = 1'b0, txs = 1'b1;
   logic [4:0] lvl = 5'h00;
   logic [1:0] trg = 2'h0;
   logic [3:0] lines = 4'h0;
   logic [7:0] rdata_o;
   logic rxs, start, stall, ev, txp, rts_n, dtr_n, cts_n, dsr_n, ri_n, dcd_n, rxd;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   // Rows: control value, expected dtr_n, expected rts_n; reserved bits left zero
   logic [9:0] rows [5] = '{10'h003, 10'h005, 10'h00a, 10'h00c, 10'h203};
   logic [4:0] hi [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
   logic [4:0] lo [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
   umf_top #(.LEVEL_W(5)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .rx_level_i(lvl),
      .rx_trigger_i(trg), .rx_serial_o(rxs), .tx_serial_i(txs), .tx_start_req_i(req),
      .tx_busy_i(busy), .tx_start_o(start), .tx_stalled_o(stall), .modem_status_event_o(ev),
      .serial_rx_pin_i(rxd), .serial_tx_pin_o(txp), .clear_to_send_in_n_i(cts_n),
      .dsr_n_i(dsr_n), .ri_n_i(ri_n), .dcd_n_i(dcd_n), .request_to_send_out_n_o(rts_n),
      .dtr_n_o(dtr_n));
   umf_remote i_rem (.clk_i(clk_i), .rts_n_i(rts_n), .go_i(go), .lines_i(lines),
      .cts_n_o(cts_n), .dsr_n_o(dsr_n), .ri_n_o(ri_n), .dcd_n_o(dcd_n), .rxd_o(rxd));
   // Clock and hang guard
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [31:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [31:0] a);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata_o;
   endtask : rd_reg
   task automatic rst_chk();
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      tick(0);
      chk(dtr_n, 1'b1, "dtr_n");
      chk(rts_n, 1'b1, "rts_n");
      rd_reg(`UMF_MCR_ADDR);
      chk(d, 8'h00, "control");
   endtask : rst_chk
   initial begin
      rst_chk();
      foreach (rows[i]) begin
         wr_reg(`UMF_MCR_ADDR, rows[i][9:2]);
         tick(1);
         chk(dtr_n, rows[i][1], "dtr_n");
         chk(rts_n, rows[i][0], "rts_n");
         rd_reg(`UMF_MCR_ADDR);
         chk(d, rows[i][9:2], "control");
      end
      // Loopback with a remote frame under way and all pins asserted
      wr_reg(`UMF_MCR_ADDR, 8'h02);
      go <= 1'b1;
      txs <= 1'b0;
      @(posedge clk_i);
      lines <= 4'hf;
      wr_reg(`UMF_MCR_ADDR, 8'h10);
      rd_reg(`UMF_MSR_ADDR);
      rd_reg(`UMF_MSR_ADDR);
      chk(d, 8'h00, "status");
      chk(rxs, 1'b0, "rx_serial");
      chk(txp, 1'b1, "tx_pin");
      chk({dtr_n, rts_n}, 2'b11, "modem outs");
      wr_reg(`UMF_MCR_ADDR, 8'h1f);
      tick(1);
      chk(ev, 1'b1, "event");
      rd_reg(`UMF_MCR_ADDR);
      chk(d, 8'h1c, "control");
      rd_reg(`UMF_MSR_ADDR);
      chk(d, 8'hfb, "status");
      @(posedge clk_i);
      txs <= 1'b1;
      go <= 1'b0;
      tick(2);
      chk(rxs, 1'b1, "rx_serial");
      wr_reg(`UMF_MCR_ADDR, 8'h00);
      tick(3);
      rd_reg(`UMF_MSR_ADDR);
      chk(d[7:4], 4'hf, "status");
      // Automatic request-to-send for every trigger code
      lines <= 4'h0;
      wr_reg(`UMF_MCR_ADDR, 8'h40);
      for (int c = 0; c < 4; c++) begin
         @(posedge clk_i);
         trg <= c[1:0];
         lvl <= hi[c] - 5'h01;
         tick(3);
         chk(rts_n, 1'b0, "rts_n");
         @(posedge clk_i);
         lvl <= hi[c];
         tick(3);
         chk(rts_n, 1'b1, "rts_n");
         wr_reg(`UMF_MCR_ADDR, 8'h42);
         rd_reg(`UMF_MCR_ADDR);
         chk(d[1], 1'b0, "rts bit");
         @(posedge clk_i);
         lvl <= lo[c] + 5'h01;
         tick(3);
         chk(rts_n, 1'b1, "rts_n");
         @(posedge clk_i);
         lvl <= lo[c];
         tick(3);
         chk(rts_n, 1'b0, "rts_n");
         rd_reg(`UMF_MCR_ADDR);
         chk(d[1], 1'b1, "rts bit");
      end
      // Automatic clear-to-send: stall, release, grant
      @(posedge clk_i);
      lvl <= 5'h00;
      wr_reg(`UMF_MCR_ADDR, 8'h80);
      @(posedge clk_i);
      req <= 1'b1;
      tick(1);
      chk(start, 1'b0, "tx_start");
      chk({stall, txp}, 2'b11, "stall");
      @(posedge clk_i);
      lines <= 4'h1;
      tick(2);
      chk(start, 1'b0, "tx_start");
      tick(1);
      chk(start, 1'b1, "tx_start");
      @(posedge clk_i);
      req <= 1'b0;
      busy <= 1'b1;
      tick(0);
      chk(stall, 1'b0, "stall");
      @(posedge clk_i);
      busy <= 1'b0;
      lines <= 4'h0;
      wr_reg(`UMF_MCR_ADDR, 8'h00);
      @(posedge clk_i);
      req <= 1'b1;
      tick(0);
      chk(start, 1'b1, "tx_start");
      @(posedge clk_i);
      req <= 1'b0;
      rst_chk();
      end_of_test();
   end
endmodule : tb_umf_top
`default_nettype wire
